/* rtl/squib_diag_pkg.sv */
// constants shared by the squib diagnostic device and its spi controller
package squib_diag_pkg;
  // ****************************************************
  // command bytes and command groups
  // ****************************************************
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_HS_UNLOCK = 8'h82;
  localparam logic [7:0] CMD_LS_UNLOCK = 8'h83;
  localparam logic [7:0] CMD_COMPARATOR = 8'h79;
  localparam logic [7:0] CMD_THERMAL = 8'h7F;
  localparam logic [3:0] GRP_HS_TEST = 4'h1;
  localparam logic [3:0] GRP_LS_TEST = 4'h2;
  localparam logic [3:0] GRP_TIMER_CLEAR = 4'h3;
  localparam logic [3:0] GRP_MEAS_READ = 4'h7;
  localparam int unsigned CHANNELS = 4;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
  localparam logic [3:0] FRAME_BITS = 4'h8;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned SHUTDOWN_MIN_NS = 2090000;
  localparam int unsigned SHUTDOWN_MIN_CYCLES = (SHUTDOWN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MEAS_STEP_NS = 1000;
  localparam logic [4:0] MEAS_STEP_CYCLES = 5'((MEAS_STEP_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned SCLK_HALF_NS = 160;
  localparam logic [3:0] SCLK_HALF_CYCLES = 4'(SCLK_HALF_NS / CLK_NS);
  // ****************************************************
  // controller register map (byte addresses)
  // ****************************************************
  localparam logic [3:0] REG_TX = 4'h0;
  localparam logic [3:0] REG_RX = 4'h4;
  localparam logic [3:0] REG_PINS = 4'h8;
  localparam int unsigned RX_BUSY_BIT = 8;
  localparam int unsigned PIN_FEN1_BIT = 0;
  localparam int unsigned PIN_FEN2_BIT = 1;
  localparam int unsigned PIN_RST_BIT = 2;
  localparam logic [2:0] PINS_RESET = 3'h4;
endpackage : squib_diag_pkg

/* rtl/squib_spi_if.sv */
// spi link and control pins between controller and squib device
`timescale 1ns/1ps
`default_nettype none
interface squib_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic fire_enable_pin_one;
  logic fire_enable_pin_two;
  logic reset_pin_n;
  modport controller (
    output sclk,
    output cs_n,
    output mosi,
    input miso,
    output fire_enable_pin_one,
    output fire_enable_pin_two,
    output reset_pin_n
  );
  modport squib_dev (
    input sclk,
    input cs_n,
    input mosi,
    output miso,
    input fire_enable_pin_one,
    input fire_enable_pin_two,
    input reset_pin_n
  );
endinterface : squib_spi_if
`default_nettype wire

/* rtl/squib_diag_device.sv */
// squib driver diagnostics: timing, thermal latch and driver transistor test
// Operation
// [R1] one 8-bit timing register per channel
// [R2] timing runs while channel high side on
// [R3] count advances only above measurement threshold
// [R4] power-on reset clears timing registers
// [R5] command 79 reports comparator status
// [R6] result shifted out on next command
// [R7] command 3X clears selected timing registers
// [R8] no thermal shutdown before 2.09 ms on
// [R9] shutdown affects only its own driver
// [R10] thermal status latched by command 7F
// [R11] thermal latch cleared after next command
// [R12] activation only when thermal status zero
// [R13] unlock accepted only with enables low
// [R14] unlock bytes 82 and 83 echoed
// [R15] any firing enable aborts transistor test
// [R16] unlock suspends diagnostics until second write
// [R17] 82 then 1X, 83 then 2X
// [R18] test drive current limited, host times
// [R19] new unlock stops previous transistor test
// [R20] fail bit one if driver stayed off
// [R21] unlock clears test status bits
// [R22] reset pin low clears functions, shifting
// [R23] low nibble bits map 1A,1B,2A,2B
// [R24] timing counts saturate at maximum
`timescale 1ns/1ps
`default_nettype none
module squib_diag_device
  import squib_diag_pkg::*;
#(
  parameter int unsigned SHUTDOWN_MIN_CYC = SHUTDOWN_MIN_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  squib_spi_if.squib_dev spi,
  input wire logic [3:0] fire_request,
  input wire logic [3:0] firing_current_meas_threshold,
  input wire logic [3:0] over_temp,
  input wire logic [3:0] squib_sense_input,
  output logic [3:0] squib_high_output,
  output logic [3:0] squib_low_output,
  output logic [3:0] thermal_shutdown,
  output logic test_current_limit
);
  // ****************************************************
  // types and functions
  // ****************************************************
  typedef enum logic [1:0] {LOCKED, HS_ARMED, LS_ARMED} unlock_t;

  // saturating increment of a timing count
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == TIMER_MAX) ? v : v + 8'h01;
  endfunction : sat_inc

  // ****************************************************
  // pin synchronisers and edge detection
  // ****************************************************
  logic [17:0] sync1;
  logic [17:0] sync2;
  logic sclk_q;
  logic cs_q;
  wire [17:0] pins_raw = {over_temp, firing_current_meas_threshold, squib_sense_input,
    spi.reset_pin_n, spi.fire_enable_pin_two, spi.fire_enable_pin_one, spi.mosi,
    spi.cs_n, spi.sclk};

  // two flops on every outside input except fire_request
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= 18'h00000;
      sync2 <= 18'h00000;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end
    else
    begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sclk_q <= sync2[0];
      cs_q <= sync2[1];
    end
  end

  wire sclk_s = sync2[0];
  wire cs_s = sync2[1];
  wire mosi_s = sync2[2];
  wire fen1_s = sync2[3];
  wire fen2_s = sync2[4];
  wire pin_reset = ~sync2[5];
  wire [3:0] sense_s = sync2[9:6];
  wire [3:0] meas_s = sync2[13:10];
  wire [3:0] over_s = sync2[17:14];
  wire sclk_rise = sclk_s & ~sclk_q;
  wire sclk_fall = ~sclk_s & sclk_q;
  wire cs_fall = ~cs_s & cs_q;
  wire cs_rise = cs_s & ~cs_q;

  // ****************************************************
  // spi shift registers
  // ****************************************************
  logic [7:0] in_shift;
  logic [7:0] out_shift;
  logic [3:0] bit_cnt;
  logic [7:0] resp;

  // shift in on sclk rise, out on sclk fall, load answer on cs fall
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_shift <= CMD_NOP;
      out_shift <= 8'h00;
      bit_cnt <= 4'h0;
    end
    else if (pin_reset) // R22
    begin
      in_shift <= CMD_NOP;
      out_shift <= 8'h00;
      bit_cnt <= 4'h0;
    end
    else if (cs_fall)
    begin
      out_shift <= resp; // R6
      bit_cnt <= 4'h0;
    end
    else if (!cs_s && sclk_rise)
    begin
      in_shift <= {in_shift[6:0], mosi_s};
      bit_cnt <= (bit_cnt == 4'hF) ? bit_cnt : bit_cnt + 4'h1;
    end
    else if (!cs_s && sclk_fall)
    begin
      out_shift <= {out_shift[6:0], 1'b0};
    end
  end

  assign spi.miso = out_shift[7];

  // ****************************************************
  // command decode
  // ****************************************************
  unlock_t unlock;
  logic [3:0] hs_test;
  logic [3:0] ls_test;
  logic [3:0] hs_fail;
  logic [3:0] ls_fail;
  logic [7:0] timing [CHANNELS];
  wire exec = cs_rise & (bit_cnt == FRAME_BITS) & ~pin_reset;
  wire [3:0] grp = in_shift[7:4];
  wire [3:0] sel = in_shift[3:0]; // R23
  wire fire_enabled = fen1_s | fen2_s;
  wire unlock_ok = ~fen1_s & ~fen2_s; // R13
  wire is_unlock = (in_shift == CMD_HS_UNLOCK) | (in_shift == CMD_LS_UNLOCK);
  wire do_unlock = exec & is_unlock & unlock_ok;
  wire in_unlock = exec & ~do_unlock & (unlock != LOCKED);
  wire normal = exec & ~do_unlock & (unlock == LOCKED);
  wire [3:0] timer_clear = (normal && grp == GRP_TIMER_CLEAR) ? sel : 4'h0; // R7
  wire [7:0] meas_byte = (sel < 4'h4) ? timing[sel[1:0]] : 8'h00;

  // answer byte for the next frame
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      resp <= 8'h00;
    else if (pin_reset)
      resp <= 8'h00;
    else if (do_unlock)
      resp <= in_shift; // R14
    else if (in_unlock)
      resp <= {hs_fail, ls_fail}; // R20
    else if (normal)
    begin
      if (in_shift == CMD_COMPARATOR)
        resp <= {4'h0, meas_s}; // R5
      else if (in_shift == CMD_THERMAL)
        resp <= {4'h0, thermal_shutdown}; // R10
      else if (grp == GRP_MEAS_READ)
        resp <= meas_byte;
      else
        resp <= {hs_fail, ls_fail}; // R11
    end
  end

  // unlock sequencing and transistor test selection
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      unlock <= LOCKED;
      hs_test <= 4'h0;
      ls_test <= 4'h0;
    end
    else if (pin_reset || fire_enabled) // R15
    begin
      unlock <= LOCKED;
      hs_test <= 4'h0;
      ls_test <= 4'h0;
    end
    else if (do_unlock)
    begin
      unlock <= (in_shift == CMD_HS_UNLOCK) ? HS_ARMED : LS_ARMED; // R16
      hs_test <= 4'h0; // R19
      ls_test <= 4'h0;
    end
    else if (in_unlock)
    begin
      unlock <= LOCKED;
      if (unlock == HS_ARMED && grp == GRP_HS_TEST)
        hs_test <= sel; // R17
      if (unlock == LS_ARMED && grp == GRP_LS_TEST)
        ls_test <= sel; // R17
    end
  end

  // test status: one while a tested driver has not turned on
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hs_fail <= 4'h0;
      ls_fail <= 4'h0;
    end
    else if (pin_reset || do_unlock) // R21
    begin
      hs_fail <= 4'h0;
      ls_fail <= 4'h0;
    end
    else
    begin
      hs_fail <= (hs_fail & ~hs_test) | (hs_test & ~sense_s); // R20
      ls_fail <= (ls_fail & ~ls_test) | (ls_test & ~sense_s); // R20
    end
  end

  // ****************************************************
  // firing drive, thermal shutdown and timing registers
  // ****************************************************
  logic [4:0] step_cnt;
  logic [21:0] on_cnt [CHANNELS];
  wire step_tick = (step_cnt == MEAS_STEP_CYCLES - 5'h01);
  wire [3:0] hs_fire = fire_request & {4{fire_enabled & ~pin_reset}} & ~thermal_shutdown; // R12

  // common time step for the timing registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      step_cnt <= 5'h00;
    else
      step_cnt <= step_tick ? 5'h00 : step_cnt + 5'h01;
  end

  // per channel on-time, shutdown and timing count, one process so each array has one driver
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      thermal_shutdown <= 4'h0;
      for (int ch = 0; ch < CHANNELS; ch++)
      begin
        on_cnt[ch] <= 22'h000000;
        timing[ch] <= TIMER_RESET; // R4
      end
    end
    else
      for (int ch = 0; ch < CHANNELS; ch++)
      begin
        on_cnt[ch] <= hs_fire[ch] ? on_cnt[ch] + 22'h000001 : 22'h000000;
        if (!over_s[ch])
          thermal_shutdown[ch] <= 1'b0;
        else if (hs_fire[ch] && on_cnt[ch] >= 22'(SHUTDOWN_MIN_CYC - 1))
          thermal_shutdown[ch] <= 1'b1; // R8 R9
        if (timer_clear[ch])
          timing[ch] <= TIMER_RESET; // R7
        else if (step_tick && hs_fire[ch] && meas_s[ch])
          timing[ch] <= sat_inc(timing[ch]); // R1 R2 R3 R24
      end
  end

  // registered driver outputs
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      squib_high_output <= 4'h0;
      squib_low_output <= 4'h0;
      test_current_limit <= 1'b0;
    end
    else
    begin
      squib_high_output <= hs_fire | hs_test;
      squib_low_output <= hs_fire | ls_test;
      test_current_limit <= |(hs_test | ls_test); // R18
    end
  end
endmodule : squib_diag_device
`default_nettype wire

/* rtl/squib_diag_controller.sv */
// spi controller with avalon-mm registers driving the squib device link
`timescale 1ns/1ps
`default_nettype none
module squib_diag_controller
  import squib_diag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  squib_spi_if.controller spi,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ****************************************************
  // state and registers
  // ****************************************************
  typedef enum logic [2:0] {IDLE, LEAD, HIGH, LOW, TAIL, GAP} phase_t;
  phase_t phase;
  logic [3:0] div_cnt;
  logic [2:0] bit_idx;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic [7:0] rx_byte;
  logic [2:0] pins;
  logic miso_m;
  logic miso_s;

  wire busy = (phase != IDLE);
  wire half_done = (div_cnt == SCLK_HALF_CYCLES - 4'h1);
  wire tx_hit = avs_write & (avs_address == REG_TX);
  wire tx_take = tx_hit & ~busy; // tx write accepted only while no frame is running
  wire pins_take = avs_write & (avs_address == REG_PINS);

  // ****************************************************
  // avalon-mm slave
  // ****************************************************
  assign avs_waitrequest = tx_hit & busy;
  assign avs_readdata = !avs_read ? 32'h0 : (avs_address == REG_RX) ? {23'h0, busy, rx_byte} :
                        (avs_address == REG_PINS) ? {29'h0, pins} : 32'h0;

  // pin levels written by software
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pins <= PINS_RESET;
    else if (pins_take)
      pins <= avs_writedata[2:0];
  end

  assign spi.fire_enable_pin_one = pins[PIN_FEN1_BIT];
  assign spi.fire_enable_pin_two = pins[PIN_FEN2_BIT];
  assign spi.reset_pin_n = pins[PIN_RST_BIT]; // R22

  // miso synchroniser
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end
    else
    begin
      miso_m <= spi.miso;
      miso_s <= miso_m;
    end
  end

  // ****************************************************
  // frame sequencer: one 8-bit frame per tx write
  // ****************************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase <= IDLE;
      div_cnt <= 4'h0;
      bit_idx <= 3'h0;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      rx_byte <= 8'h00;
      spi.sclk <= 1'b0;
      spi.cs_n <= 1'b1;
      spi.mosi <= 1'b0;
    end
    else
    begin
      div_cnt <= (busy && !half_done) ? div_cnt + 4'h1 : 4'h0;
      case (phase)
        IDLE:
          if (tx_take)
          begin
            tx_shift <= avs_writedata[7:0]; // R7 R17
            spi.mosi <= avs_writedata[7];
            spi.cs_n <= 1'b0;
            bit_idx <= 3'h0;
            phase <= LEAD;
          end
        LEAD, LOW:
          if (half_done)
          begin
            spi.sclk <= 1'b1;
            phase <= HIGH;
          end
        HIGH:
          if (half_done)
          begin
            rx_shift <= {rx_shift[6:0], miso_s};
            spi.sclk <= 1'b0;
            tx_shift <= {tx_shift[6:0], 1'b0};
            spi.mosi <= tx_shift[6];
            bit_idx <= bit_idx + 3'h1;
            phase <= (bit_idx == 3'h7) ? TAIL : LOW;
          end
        TAIL:
          if (half_done)
          begin
            spi.cs_n <= 1'b1;
            rx_byte <= rx_shift;
            phase <= GAP;
          end
        GAP:
          if (half_done)
            phase <= IDLE;
        default:
          phase <= IDLE;
      endcase
    end
  end
endmodule : squib_diag_controller
`default_nettype wire

/* verification/squib_diag_assertions.sv */
// concurrent checks on the squib spi link and device drive outputs
`timescale 1ns/1ps
`default_nettype none
module squib_diag_assertions
  import squib_diag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic fire_enable_pin_one,
  input wire logic fire_enable_pin_two,
  input wire logic reset_pin_n,
  input wire logic [3:0] squib_high_output,
  input wire logic [3:0] squib_low_output,
  input wire logic [3:0] thermal_shutdown,
  input wire logic test_current_limit
);
  logic sclk_d;
  logic [3:0] rises;
  logic fen;
  assign fen = fire_enable_pin_one | fire_enable_pin_two;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // counts sclk rises while a frame is open
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_d <= 1'b0;
      rises <= 4'h0;
    end
    else
    begin
      sclk_d <= sclk;
      rises <= cs_n ? 4'h0 : rises + 4'(sclk & ~sclk_d);
    end
  end
  // ****************
  // link framing
  // ****************
  sequence sclk_high_run;
    sclk[*4] ##1 !sclk;
  endsequence
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("sclk active outside frame");
  chk_sclk_pulse: assert property ($rose(sclk) |-> sclk_high_run)
    else $error("sclk high phase wrong length");
  chk_mosi_hold: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  chk_cs_gap: assert property ($rose(cs_n) |-> cs_n[*4])
    else $error("frame gap too short");
  chk_frame_bits: assert property ($rose(cs_n) |-> rises == FRAME_BITS)
    else $error("frame not eight bits");
  // ****************
  // drive outputs
  // ****************
  chk_fire_abort: assert property (fen[*6] |-> !test_current_limit)
    else $error("test still driven with firing enabled");
  chk_test_exclusive: assert property
    (test_current_limit |-> !((|squib_high_output) && (|squib_low_output)))
    else $error("high and low side tested together");
  chk_thermal_block: assert property
    (!test_current_limit |-> (squib_high_output & thermal_shutdown
      & $past(thermal_shutdown)) == 4'h0)
    else $error("driver on during thermal shutdown");
  chk_reset_pin: assert property
    (!reset_pin_n[*6] |-> !test_current_limit && squib_high_output == 4'h0)
    else $error("drive on while reset pin low");
endmodule : squib_diag_assertions
`default_nettype wire

/* verification/tb.sv */
// self-checking bench: controller and squib device joined over the spi link
`timescale 1ns/1ps
`default_nettype none
module tb
  import squib_diag_pkg::*;
;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] fire_request = 4'h0;
  logic [3:0] thr = 4'h0;
  logic [3:0] over_temp = 4'h0;
  logic [3:0] sense = 4'h0;
  logic [3:0] hi, lo, therm;
  logic tcl;
  int fails = 0;
  int check_count = 0;
  squib_spi_if spi_link ();
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  // ****************
  // design and checker
  // ****************
  squib_diag_device #(.SHUTDOWN_MIN_CYC(20)) u_squib_diag_device (
    .clk_sys(clk_sys), .arst_n(arst_n), .spi(spi_link), .fire_request(fire_request),
    .firing_current_meas_threshold(thr), .over_temp(over_temp),
    .squib_sense_input(sense), .squib_high_output(hi), .squib_low_output(lo),
    .thermal_shutdown(therm), .test_current_limit(tcl));
  squib_diag_controller u_squib_diag_controller (
    .clk_sys(clk_sys), .arst_n(arst_n), .spi(spi_link), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  squib_diag_assertions u_squib_diag_assertions (
    .clk_sys(clk_sys), .arst_n(arst_n), .sclk(spi_link.sclk), .cs_n(spi_link.cs_n),
    .mosi(spi_link.mosi), .fire_enable_pin_one(spi_link.fire_enable_pin_one),
    .fire_enable_pin_two(spi_link.fire_enable_pin_two),
    .reset_pin_n(spi_link.reset_pin_n), .squib_high_output(hi),
    .squib_low_output(lo), .thermal_shutdown(therm), .test_current_limit(tcl));
  // ****************
  // tasks
  // ****************
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : cmp
  // one avalon cycle, held until waitrequest is seen low
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    n = 0;
    // values read right after the edge are those the slave saw at that edge
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 400);
    if (avs_waitrequest !== 1'b0)
    begin
      fails++;
      close_out();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  // one spi frame; returns the answer to the previous frame
  task automatic xfer(input logic [7:0] c, output logic [7:0] ans);
    logic [31:0] q;
    int n;
    av(REG_TX, 1'b1, {24'h0, c}, q);
    n = 0;
    do
    begin
      av(REG_RX, 1'b0, 32'h0, q);
      n++;
    end
    while (q[RX_BUSY_BIT] !== 1'b0 && n < 200);
    if (q[RX_BUSY_BIT] !== 1'b0)
    begin
      fails++;
      close_out();
    end
    ans = q[7:0];
  endtask : xfer
  task automatic rd(input logic [7:0] c, output logic [7:0] ans);
    logic [7:0] x;
    xfer(c, x);
    xfer(CMD_NOP, ans);
  endtask : rd
  task automatic pins(input logic [2:0] p);
    logic [31:0] q;
    av(REG_PINS, 1'b1, {29'h0, p}, q);
  endtask : pins
  task automatic timers(input string nm, input logic [3:0] full);
    logic [7:0] a;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h70 + 8'(i), a);
      cmp(nm, full[i] ? TIMER_MAX : TIMER_RESET, a);
    end
  endtask : timers
  function automatic logic [7:0] fail_byte(input logic [3:0] hs, input logic [3:0] ls,
                                           input logic [3:0] s);
    return {hs & ~s, ls & ~s};
  endfunction : fail_byte
  // ****************
  // main sequence
  // ****************
  initial
  begin
    logic [7:0] a;
    logic [31:0] q;
    logic [3:0] m;
    logic [3:0] s;
    void'($urandom(32'hB138));
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    av(REG_PINS, 1'b0, 32'h0, q);
    cmp("pins_reset", {5'h0, PINS_RESET}, q[7:0]);
    av(4'hC, 1'b0, 32'h0, q);
    cmp("unmapped", 8'h00, q[7:0]);
    timers("timer_reset", 4'h0);
    repeat (3)
    begin
      thr <= 4'($urandom);
      rd(CMD_COMPARATOR, a);
      cmp("comparator", {4'h0, thr}, a);
    end
    // ch0 and ch2 saturate, ch1 below threshold, ch3 never driven
    thr <= 4'b1101;
    fire_request <= 4'b0111;
    pins(3'h5);
    repeat (6700) @(posedge clk_sys);
    fire_request <= 4'h0;
    pins(3'h4);
    timers("timer_fire", 4'b0101);
    rd({GRP_TIMER_CLEAR, 4'b0100}, a);
    timers("timer_clear", 4'b0001);
    // ch1 overheats while ch0 keeps firing
    over_temp <= 4'b0010;
    fire_request <= 4'b0011;
    pins(3'h5);
    repeat (10) @(negedge clk_sys);
    cmp("therm_early", 8'h00, {4'h0, therm});
    repeat (60) @(negedge clk_sys);
    cmp("therm_set", 8'h02, {4'h0, therm});
    cmp("drive", 8'h01, {4'h0, hi});
    rd(CMD_THERMAL, a);
    cmp("therm_latch", 8'h02, a);
    xfer(CMD_NOP, a);
    cmp("therm_clear", 8'h00, a);
    over_temp <= 4'h0;
    fire_request <= 4'h0;
    pins(3'h4);
    // high side test, then low side test
    s = 4'($urandom);
    sense <= s;
    xfer(CMD_HS_UNLOCK, a);
    xfer({GRP_HS_TEST, 4'hF}, a);
    cmp("echo_hs", CMD_HS_UNLOCK, a);
    @(negedge clk_sys);
    cmp("hs_drive", 8'h8F, {tcl, 3'h0, hi});
    rd(CMD_NOP, a);
    cmp("hs_fail", fail_byte(4'hF, 4'h0, s), a);
    xfer(CMD_LS_UNLOCK, a);
    @(negedge clk_sys);
    cmp("hs_stop", 8'h00, {tcl, 3'h0, hi});
    m = 4'($urandom_range(15, 1));
    s = 4'($urandom);
    @(posedge clk_sys);
    sense <= s;
    xfer({GRP_LS_TEST, m}, a);
    cmp("echo_ls", CMD_LS_UNLOCK, a);
    @(negedge clk_sys);
    cmp("ls_drive", {4'h8, m}, {tcl, 3'h0, lo});
    rd(CMD_NOP, a);
    cmp("ls_fail", fail_byte(4'h0, m, s), a);
    // firing enable aborts the test and refuses an unlock
    pins(3'h5);
    repeat (10) @(negedge clk_sys);
    cmp("abort", 8'h00, {tcl, 3'h0, lo});
    xfer(CMD_HS_UNLOCK, a);
    xfer({GRP_HS_TEST, 4'hF}, a);
    cmp("no_echo", fail_byte(4'h0, m, s), a);
    @(negedge clk_sys);
    cmp("no_test", 8'h00, {tcl, 3'h0, hi});
    // reset pin low stops a running test
    pins(3'h4);
    xfer(CMD_HS_UNLOCK, a);
    xfer({GRP_HS_TEST, 4'hF}, a);
    pins(3'h0);
    repeat (10) @(negedge clk_sys);
    cmp("rst_pin", 8'h00, {tcl, 3'h0, hi});
    pins(3'h4);
    close_out();
  end
endmodule : tb
`default_nettype wire
